// ### rtl/front_panel_regs.svh
// Offsets, field positions, reset values and timing counts of the front panel block
`ifndef FRONT_PANEL_REGS_SVH
`define FRONT_PANEL_REGS_SVH

`define FP_ADDR_W 4
`define FP_OFS_CTRL 4'h0
`define FP_OFS_STATUS 4'h4
`define FP_OFS_ADDR 4'h8
`define FP_OFS_LEDS 4'hc

`define FP_CTRL_LOCK_BIT 0
`define FP_CTRL_RST 1'h0

`define FP_ST_MODE_LO 0
`define FP_ST_STANDBY_BIT 2
`define FP_ST_Q_BIT 3
`define FP_ST_EF3_BIT 4
`define FP_ST_RDWR_BIT 5
`define FP_ST_BUSY_BIT 6

`define FP_REG_ZERO_RST 16'h0000
`define FP_LEDS_RST 8'h00

`define FP_CLK_MHZ 250
`define FP_DEBOUNCE_TIME_US 10000
`define FP_DEBOUNCE_CYCLES (`FP_DEBOUNCE_TIME_US * `FP_CLK_MHZ)

`endif

// ### rtl/front_panel_pkg.sv
// Types shared by the front panel modules
package front_panel_pkg;

  typedef enum logic [1:0] {
    MODE_LOAD = 2'b00,
    MODE_CLEAR = 2'b01,
    MODE_WAIT = 2'b10,
    MODE_RUN = 2'b11
  } panel_mode_t;

  typedef enum logic [1:0] {
    DEP_IDLE = 2'b00,
    DEP_READ = 2'b01,
    DEP_SHOW = 2'b10,
    DEP_WRITE = 2'b11
  } deposit_state_t;

endpackage

// ### rtl/button_if.sv
// Carrier between the deposit button conditioner and the panel logic
`timescale 1ns/1ps
`default_nettype none

interface button_if;
  logic raw;
  logic press;

  modport conditioner (
    input raw,
    output press
  );

  modport owner (
    output raw,
    input press
  );
endinterface

`default_nettype wire

// ### rtl/button_debounce.sv
// Synchroniser, debouncer and press detector for the deposit button
`timescale 1ns/1ps
`default_nettype none

module button_debounce #(
  parameter int unsigned STABLE_CYCLES = 2500000
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  button_if.conditioner btn
);

  localparam int unsigned CNT_W = $clog2(STABLE_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STABLE_CYCLES - 1);

  logic sync1_ff;
  logic sync2_ff;
  logic stable_ff;
  logic press_ff;
  logic [CNT_W-1:0] cnt_ff;
  wire differs = sync2_ff != stable_ff;
  wire settled = differs && (cnt_ff == CNT_LAST);

  // Second stage alone looks at the first
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= btn.raw;
      sync2_ff <= sync1_ff;
    end
  end

  // Bounces restart the count, so one press gives one pulse
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cnt_ff <= '0;
      stable_ff <= 1'b0;
      press_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= (differs && !settled) ? cnt_ff + 1'b1 : '0;
      if (settled)
      begin
        stable_ff <= sync2_ff;
      end
      press_ff <= settled && sync2_ff;
    end
  end

  assign btn.press = press_ff;

endmodule

`default_nettype wire

// ### rtl/front_panel_mode_control.sv
// Front panel mode, deposit, display and standby control with an Avalon-MM register slave
// Overview of operation
// - Both mode switches down holds the core waiting while button presses perform memory accesses.
// - Clear switch down with wait switch up resets the core and returns the program register to zero.
// - Clear switch up with wait switch down freezes the core where it stands until the mode changes.
// - Both switches up lets the core run, from address zero after a clear or onward after a wait.
// - A high or floating power control input stops the clock, blanks the LEDs and holds the core in reset.
// - A low power control input enables the clock and LEDs and lets the core run.
// - The mode switches override standby except while the wait switch is up.
// - The write position of the read/write switch allows memory writes; the read position blocks them.
// - A press in load mode with writes allowed stores the switch byte at the program register, shows it, and steps it.
// - The data LEDs show the latest byte deposited or read back from the panel or output by the running program.
// - The status LED shows the core Q output in red and external flag three in green.
// - A press in load mode with writes blocked reads the byte at the program register, shows it, and steps it.
//
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "front_panel_regs.svh"

module front_panel_mode_control #(
  parameter int unsigned ADDR_W = 16,
  parameter int unsigned DEBOUNCE_CYCLES = `FP_DEBOUNCE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clear_mode_switch,
  input wire logic wait_mode_switch,
  input wire logic rd_wr_switch,
  input wire logic deposit_button,
  input wire logic [7:0] data_switches,
  input wire logic power_ctrl_n,
  input wire logic ext_flag_three,
  input wire logic core_q,
  input wire logic core_mem_we,
  input wire logic core_out_valid,
  input wire logic [7:0] core_out_data,
  input wire logic [7:0] mem_rdata,
  output logic core_clk_en,
  output logic core_clear,
  output logic core_wait,
  output logic panel_mem_we,
  output logic panel_mem_re,
  output logic [ADDR_W-1:0] panel_mem_addr,
  output logic [7:0] panel_mem_wdata,
  output logic mem_we,
  output logic [7:0] data_leds,
  output logic status_led_red,
  output logic status_led_green,
  input wire logic [`FP_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // Mode decode
  wire front_panel_pkg::panel_mode_t mode = front_panel_pkg::panel_mode_t'({clear_mode_switch, wait_mode_switch});
  wire mode_load = mode == front_panel_pkg::MODE_LOAD;
  wire mode_clear = mode == front_panel_pkg::MODE_CLEAR;
  wire mode_wait = mode == front_panel_pkg::MODE_WAIT;
  wire mode_run = mode == front_panel_pkg::MODE_RUN;

  // Standby only bites while the wait switch is up
  wire standby = power_ctrl_n && wait_mode_switch;

  // Button conditioning
  button_if btn ();
  assign btn.raw = deposit_button;

  button_debounce #(
    .STABLE_CYCLES(DEBOUNCE_CYCLES)
  ) u_debounce (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .btn(btn)
  );

  // Register file state
  logic lock_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [ADDR_W-1:0] reg_zero_ff;
  logic [ADDR_W-1:0] nxt_reg_zero;
  logic [7:0] leds_ff;
  logic [7:0] nxt_leds;
  logic [7:0] data_leds_ff;
  logic red_ff;
  logic green_ff;

  // Deposit sequencer state
  front_panel_pkg::deposit_state_t dep_ff;
  front_panel_pkg::deposit_state_t nxt_dep;
  logic [7:0] wdata_ff;

  // Bus decode
  wire bus_req = avs_read || avs_write;
  wire bus_take = bus_req && !ack_ff;
  wire sel_ctrl = avs_address == `FP_OFS_CTRL;
  wire sel_status = avs_address == `FP_OFS_STATUS;
  wire sel_addr = avs_address == `FP_OFS_ADDR;
  wire sel_leds = avs_address == `FP_OFS_LEDS;
  wire wr_ctrl = bus_take && avs_write && sel_ctrl && avs_byteenable[0];
  wire wr_addr = bus_take && avs_write && sel_addr;
  wire dep_busy = dep_ff != front_panel_pkg::DEP_IDLE;

  // A press counts only in load mode, awake and unlocked
  wire press_ok = btn.press && mode_load && !standby && !lock_ff;
  wire start_wr = press_ok && rd_wr_switch;
  wire start_rd = press_ok && !rd_wr_switch;

  // Read data selection
  logic [31:0] status_word;
  logic [31:0] addr_word;
  logic [31:0] rd_mux;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[`FP_ST_MODE_LO +: 2] = mode;
    status_word[`FP_ST_STANDBY_BIT] = standby;
    status_word[`FP_ST_Q_BIT] = core_q;
    status_word[`FP_ST_EF3_BIT] = ext_flag_three;
    status_word[`FP_ST_RDWR_BIT] = rd_wr_switch;
    status_word[`FP_ST_BUSY_BIT] = dep_busy;
  end

  always_comb
  begin
    addr_word = 32'h0000_0000;
    addr_word[ADDR_W-1:0] = reg_zero_ff;
  end

  // Unmapped offsets read as zero
  assign rd_mux = sel_ctrl ? {31'h0000_0000, lock_ff} :
                  sel_status ? status_word :
                  sel_addr ? addr_word :
                  sel_leds ? {24'h00_0000, leds_ff} :
                  32'h0000_0000;

  // One wait state per access
  assign avs_waitrequest = bus_req && !ack_ff;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      lock_ff <= `FP_CTRL_RST;
    end
    else
    begin
      ack_ff <= bus_take;
      if (bus_take && avs_read)
      begin
        rdata_ff <= rd_mux;
      end
      if (wr_ctrl)
      begin
        lock_ff <= avs_writedata[`FP_CTRL_LOCK_BIT];
      end
    end
  end

  assign avs_readdata = rdata_ff;

  // Deposit sequencer
  always_comb
  begin
    nxt_dep = dep_ff;
    unique case (dep_ff)
      front_panel_pkg::DEP_IDLE:
      begin
        if (start_wr)
        begin
          nxt_dep = front_panel_pkg::DEP_WRITE;
        end
        else if (start_rd)
        begin
          nxt_dep = front_panel_pkg::DEP_READ;
        end
      end
      front_panel_pkg::DEP_WRITE:
      begin
        nxt_dep = front_panel_pkg::DEP_IDLE;
      end
      front_panel_pkg::DEP_READ:
      begin
        nxt_dep = front_panel_pkg::DEP_SHOW;
      end
      front_panel_pkg::DEP_SHOW:
      begin
        nxt_dep = front_panel_pkg::DEP_IDLE;
      end
    endcase
  end

  // Program register: cleared, stepped after each access, or loaded by software
  always_comb
  begin
    nxt_reg_zero = reg_zero_ff;
    if (mode_clear || standby)
    begin
      nxt_reg_zero = `FP_REG_ZERO_RST;
    end
    else if (dep_ff == front_panel_pkg::DEP_WRITE || dep_ff == front_panel_pkg::DEP_SHOW)
    begin
      nxt_reg_zero = reg_zero_ff + 1'b1;
    end
    else if (wr_addr && !dep_busy)
    begin
      if (avs_byteenable[0])
      begin
        nxt_reg_zero[7:0] = avs_writedata[7:0];
      end
      if (avs_byteenable[1])
      begin
        nxt_reg_zero[ADDR_W-1:8] = avs_writedata[ADDR_W-1:8];
      end
    end
  end

  // Display byte: panel deposit, panel read-back, or program output
  always_comb
  begin
    nxt_leds = leds_ff;
    if (dep_ff == front_panel_pkg::DEP_WRITE)
    begin
      nxt_leds = wdata_ff;
    end
    else if (dep_ff == front_panel_pkg::DEP_SHOW)
    begin
      nxt_leds = mem_rdata;
    end
    else if (core_out_valid && mode_run && !standby)
    begin
      nxt_leds = core_out_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      dep_ff <= front_panel_pkg::DEP_IDLE;
      wdata_ff <= 8'h00;
      reg_zero_ff <= `FP_REG_ZERO_RST;
    end
    else
    begin
      dep_ff <= nxt_dep;
      reg_zero_ff <= nxt_reg_zero;
      if (start_wr)
      begin
        wdata_ff <= data_switches;
      end
    end
  end

  // Display value is arbitrary after power-up; reset gives a known one
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      leds_ff <= `FP_LEDS_RST;
      data_leds_ff <= 8'h00;
      red_ff <= 1'b0;
      green_ff <= 1'b0;
    end
    else
    begin
      leds_ff <= nxt_leds;
      data_leds_ff <= standby ? 8'h00 : nxt_leds;
      red_ff <= core_q && !standby;
      green_ff <= ext_flag_three && !standby;
    end
  end

  assign data_leds = data_leds_ff;
  assign status_led_red = red_ff;
  assign status_led_green = green_ff;

  // Panel memory port; the sequencer is the only panel master
  assign panel_mem_we = dep_ff == front_panel_pkg::DEP_WRITE;
  assign panel_mem_re = dep_ff == front_panel_pkg::DEP_READ;
  assign panel_mem_addr = reg_zero_ff;
  assign panel_mem_wdata = wdata_ff;

  // Read position blocks every write, the core's included
  assign mem_we = rd_wr_switch && (core_mem_we || panel_mem_we);

  // Core control
  assign core_clk_en = !standby;
  assign core_clear = mode_clear || standby;
  // Load and wait both park the core; only run lets it go
  assign core_wait = (mode_load || mode_wait) && !standby;

endmodule

`default_nettype wire

// ### rtl/unused_placeholder_none.sv
// Intentionally empty compilation unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### sim/front_panel_mode_control_monitor.sv
// Port-level checker for the front panel block
`timescale 1ns/1ps
`default_nettype none
module front_panel_mode_control_monitor #(
  parameter int unsigned ADDR_W = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clear_mode_switch,
  input wire logic wait_mode_switch,
  input wire logic rd_wr_switch,
  input wire logic power_ctrl_n,
  input wire logic core_q,
  input wire logic ext_flag_three,
  input wire logic [7:0] mem_rdata,
  input wire logic core_clk_en,
  input wire logic core_clear,
  input wire logic core_wait,
  input wire logic panel_mem_we,
  input wire logic panel_mem_re,
  input wire logic [ADDR_W-1:0] panel_mem_addr,
  input wire logic [7:0] panel_mem_wdata,
  input wire logic mem_we,
  input wire logic [7:0] data_leds,
  input wire logic status_led_red,
  input wire logic status_led_green
);
  // Standby only counts with the wait switch up
  wire logic sb = power_ctrl_n & wait_mode_switch;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  a_clk_gate: assert property (core_clk_en == !sb) else $error("clock enable wrong");
  a_clear_ctl: assert property (core_clear == ((!clear_mode_switch && wait_mode_switch) || sb))
    else $error("core clear wrong");
  a_hold_ctl: assert property (!wait_mode_switch |-> core_wait && !core_clear)
    else $error("core hold wrong");
  a_run_free: assert property (clear_mode_switch && wait_mode_switch && !power_ctrl_n |-> !core_clear && !core_wait)
    else $error("core not running");
  a_write_gate: assert property (mem_we |-> rd_wr_switch) else $error("write in read position");
  a_dep_pulse: assert property (panel_mem_we |-> mem_we ##1 !panel_mem_we) else $error("deposit strobe");
  a_dep_show: assert property (panel_mem_we |=> data_leds == $past(panel_mem_wdata))
    else $error("deposit not shown");
  a_read_show: assert property (panel_mem_re |-> ##2 data_leds == $past(mem_rdata))
    else $error("read byte not shown");
  a_addr_step: assert property (panel_mem_we || panel_mem_re |-> ##2 panel_mem_addr == $past(panel_mem_addr, 2) + 1'b1)
    else $error("address not stepped");
  a_led_blank: assert property (sb ##1 sb |-> data_leds == 8'h00 && !status_led_red && !status_led_green)
    else $error("leds lit in standby");
  a_status_mirror: assert property (!sb ##1 !sb |-> status_led_red == $past(core_q) && status_led_green == $past(ext_flag_three))
    else $error("status led wrong");
endmodule
bind front_panel_mode_control front_panel_mode_control_monitor #(.ADDR_W(ADDR_W)) i_monitor (.*);
`default_nettype wire

// ### sim/core_mem_model.sv
// Behavioural program memory behind the front panel
`timescale 1ns/1ps
`default_nettype none
module core_mem_model (
  input wire logic clk_sys,
  input wire logic [15:0] panel_mem_addr,
  input wire logic [7:0] panel_mem_wdata,
  input wire logic mem_we,
  input wire logic panel_mem_re,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem_ff [256];
  // Only 256 bytes modelled; enough for the panel tests
  always_ff @(posedge clk_sys)
  begin
    if (mem_we)
      mem_ff[panel_mem_addr[7:0]] <= panel_mem_wdata;
    // Bus churns between reads so a stale byte never passes as fresh
    mem_rdata <= panel_mem_re ? mem_ff[panel_mem_addr[7:0]] : ~mem_rdata;
  end
endmodule
`default_nettype wire

// ### sim/tb_front_panel_mode_control.sv
// Self-checking bench for the front panel mode control block
`timescale 1ns/1ps
`default_nettype none
module tb_front_panel_mode_control;
  // Short debounce keeps each press under fifty cycles
  localparam int unsigned DEB = 8;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic clear_mode_switch, wait_mode_switch, rd_wr_switch, deposit_button, power_ctrl_n, ext_flag_three, core_q;
  logic core_mem_we, core_out_valid, core_clk_en, core_clear, core_wait, panel_mem_we, panel_mem_re, mem_we;
  logic status_led_red, status_led_green, avs_read, avs_write, avs_waitrequest;
  logic [7:0] data_switches, core_out_data, mem_rdata, panel_mem_wdata, data_leds, b;
  logic [7:0] img [5];
  logic [15:0] panel_mem_addr;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  wire logic [3:0] avs_byteenable = 4'hf;
  int errors = 0;
  int checked = 0;

  always #2 clk_sys = ~clk_sys;

  front_panel_mode_control #(.DEBOUNCE_CYCLES(DEB)) i_front_panel_mode_control (.*);
  core_mem_model i_core_mem_model (.*);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    logic ack;
    n = 0;
    ack = 1'b0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    // Settled mid-cycle value is what the next rising edge samples
    do
    begin
      @(negedge clk_sys);
      n++;
      ack = (avs_waitrequest === 1'b0);
      rd = avs_readdata;
      @(posedge clk_sys);
    end
    while (!ack && n < 64);
    if (!ack)
      errors++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Bounces first, then holds and releases for longer than the debounce span
  task automatic press(input logic [7:0] sw);
    data_switches <= sw;
    repeat (3)
    begin
      @(posedge clk_sys);
      deposit_button <= ~deposit_button;
    end
    repeat (DEB + 10) @(posedge clk_sys);
    deposit_button <= 1'b0;
    repeat (DEB + 10) @(posedge clk_sys);
  endtask

  // Expected {clock enable, clear, hold} from {clear, wait, power}
  function automatic logic [31:0] ctl(input logic [2:0] v);
    logic sb;
    sb = v[1] & v[0];
    return {29'h0, !sb, (v[2:1] == 2'b01) | sb, !v[1]};
  endfunction

  task automatic tally_and_finish;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    {clear_mode_switch, wait_mode_switch, rd_wr_switch, deposit_button, power_ctrl_n} = 5'b01000;
    {ext_flag_three, core_q, core_mem_we, core_out_valid, avs_read, avs_write} = 6'h0;
    {data_switches, core_out_data, avs_address, avs_writedata} = '0;
    void'($urandom(32'h785a));
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    bus(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 4'h1, 32'h0);
    chk(rd, 32'h0);
    wait_mode_switch <= 1'b0;
    rd_wr_switch <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      b = (i == 0) ? 8'hff : 8'($urandom);
      img[i] = b;
      press(b);
      chk({24'h0, data_leds}, {24'h0, b});
      bus(1'b0, 4'h8, 32'h0);
      chk(rd, 32'(i + 1));
    end
    bus(1'b1, 4'h8, 32'h0);
    rd_wr_switch <= 1'b0;
    core_mem_we <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      press(~img[i]);
      chk({24'h0, data_leds}, {24'h0, img[i]});
      chk({31'h0, mem_we}, 32'h0);
    end
    core_mem_we <= 1'b0;
    // Locked panel ignores the button; display register mirrors the LEDs
    bus(1'b1, 4'h0, 32'h1);
    press(8'h11);
    bus(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h5);
    bus(1'b0, 4'hc, 32'h0);
    chk(rd, {24'h0, img[4]});
    bus(1'b1, 4'h0, 32'h0);
    clear_mode_switch <= 1'b1;
    press(8'h5a);
    bus(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h5);
    chk({24'h0, data_leds}, {24'h0, img[4]});
    wait_mode_switch <= 1'b1;
    core_out_data <= 8'($urandom);
    core_out_valid <= 1'b1;
    core_q <= 1'b1;
    @(posedge clk_sys);
    core_out_valid <= 1'b0;
    b = core_out_data;
    @(posedge clk_sys);
    chk({24'h0, data_leds}, {24'h0, b});
    chk({30'h0, status_led_red, status_led_green}, 32'h2);
    core_q <= 1'b0;
    ext_flag_three <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk({30'h0, status_led_red, status_led_green}, 32'h1);
    power_ctrl_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({22'h0, data_leds, status_led_red, status_led_green}, 32'h0);
    bus(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h0);
    for (int k = 0; k < 8; k++)
    begin
      {clear_mode_switch, wait_mode_switch, power_ctrl_n} <= 3'(k);
      @(posedge clk_sys);
      chk({29'h0, core_clk_en, core_clear, core_wait}, ctl(3'(k)));
    end
    tally_and_finish();
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
